// [clock_output_enable_regs.v]
`timescale 1ns/10ps
`default_nettype none
`include "clock_enable_map.vh"

module clock_output_enable_regs
(
    input  wire       clock_in,
    input  wire       reset_n_in,
    input  wire       seq_start_in,
    input  wire       seq_byte_valid_in,
    input  wire [7:0] seq_byte_in,
    input  wire [2:0] read_index_in,
    input  wire       mode_strap_in,
    input  wire       mem_src_clk_in,
    input  wire       graphics_src_clk_in,
    input  wire       ref_src_clk_in,
    output reg  [7:0] read_data_out,
    output wire       mem_clk_out_0,
    output wire       mem_clk_out_1,
    output wire       mem_clk_out_2,
    output wire       mem_clk_out_3,
    output wire       mem_clk_out_4,
    output wire       mem_clk_out_5,
    output wire       mem_clk_out_6,
    output wire       mem_clk_out_7,
    output wire       mem_clk_out_8,
    output wire       mem_clk_out_9,
    output wire       mem_clk_out_10,
    output wire       mem_clk_out_11,
    output wire       graphics_clk_free,
    output wire       graphics_clk_out_0,
    output wire       graphics_clk_out_1,
    output wire       crystal_ref_out
);

    reg  [7:0]            memory_clock_enable_low_reg;           // third byte
    reg  [7:0]            memory_graphics_clock_enable_high_reg; // fourth byte
    reg  [7:0]            peripheral_clock_enable_reg;           // fifth byte, bit 2 unused here
    reg  [7:0]            future_reserved_byte_reg;              // sixth byte, storage only
    reg  [`IDX_WIDTH-1:0] byte_index_reg;                        // position in the sequence
    reg                   index_valid_reg;                       // low once index passes the end
    reg                   mode_reg;                              // strap caught after reset release
    reg                   mode_taken_reg;                        // strap already caught
    reg  [7:0]            read_data_next;                        // read mux result
    wire                  desktop;                               // desktop mode selected
    wire [15:0]           enables;                               // per-output enable
    wire [15:0]           sources;                               // per-output source clock
    wire [15:0]           gated;                                 // per-output gated clock

    // limitation: right after reset every gate still holds the all-ones enable, so
    // outputs 10 and 11 can show one pulse in narrow mode before the decode settles;
    // the first live enable only reaches a gate during a low phase of its source,
    // which is the price of never cutting a pulse short

    // strap is caught by a clocked process after release, never in the reset branch
    always @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            mode_reg       <= 1'b0;
            mode_taken_reg <= 1'b0;
        end
        else if (!mode_taken_reg)
        begin
            // first edge after release: the strap level is taken once and then frozen
            mode_reg       <= mode_strap_in;
            mode_taken_reg <= 1'b1;
        end
    end

    // a strap moved while running is ignored until the next reset
    assign desktop = (mode_reg == `DESKTOP_STRAP);

    // sequence writes: start resets the index, each byte lands at its index
    always @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            // every enable byte powers up at all ones, so all outputs run except 10 and 11 in narrow mode
            byte_index_reg                        <= 3'h0;
            index_valid_reg                       <= 1'b1;
            memory_clock_enable_low_reg           <= `RST_MEM_LOW;
            memory_graphics_clock_enable_high_reg <= `RST_MEM_GFX_HIGH;
            peripheral_clock_enable_reg           <= `RST_PERIPHERAL;
            future_reserved_byte_reg              <= `RST_FUTURE_RSVD;
        end
        else if (seq_start_in)
        begin
            // new command sequence: the next byte is index 0
            byte_index_reg  <= 3'h0;
            index_valid_reg <= 1'b1;
        end
        else if (seq_byte_valid_in && index_valid_reg)
        begin
            // bytes 0..2 belong to other register groups and are skipped here
            // reserved bits are kept as written so the host reads back what it sent
            case (byte_index_reg)
                `IDX_MEM_LOW:      memory_clock_enable_low_reg           <= seq_byte_in;
                `IDX_MEM_GFX_HIGH: memory_graphics_clock_enable_high_reg <= seq_byte_in;
                `IDX_PERIPHERAL:   peripheral_clock_enable_reg           <= seq_byte_in;
                `IDX_FUTURE_RSVD:  future_reserved_byte_reg              <= seq_byte_in;
                default:           ;
            endcase
            // extra bytes past the last index are dropped rather than wrapping
            if (byte_index_reg == `IDX_FUTURE_RSVD)
                index_valid_reg <= 1'b0;
            // the count stops at 7 once valid is low; it is only used while valid is high
            byte_index_reg <= byte_index_reg + 3'h1;
        end
    end

    // read mux; mode bit reports the latched strap, not stored data
    always @*
    begin
        read_data_next = 8'h00;
        case (read_index_in)
            `IDX_MEM_LOW:      read_data_next = memory_clock_enable_low_reg;
            `IDX_MEM_GFX_HIGH: read_data_next = memory_graphics_clock_enable_high_reg;
            `IDX_PERIPHERAL:
            begin
                // a host write to the mode bit is stored but never shown
                read_data_next            = peripheral_clock_enable_reg;
                read_data_next[`POS_MODE] = mode_reg;
            end
            `IDX_FUTURE_RSVD:  read_data_next = future_reserved_byte_reg;
            // indices 0..2 belong to other groups and 7 is unused: they read as zero
            default:           read_data_next = 8'h00;
        endcase
    end

    // registered read data, one cycle after the index
    always @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            // nothing stored is reported while in reset
            read_data_out <= 8'h00;
        end
        else
        begin
            // the host sees the byte one cycle after it sets the index
            read_data_out <= read_data_next;
        end
    end

    // enable map; outputs 11 and 10 exist only in desktop mode
    assign enables[0]    = memory_clock_enable_low_reg[0];
    assign enables[1]    = memory_clock_enable_low_reg[1];
    assign enables[2]    = memory_clock_enable_low_reg[2];
    assign enables[3]    = memory_clock_enable_low_reg[3];
    assign enables[4]    = memory_clock_enable_low_reg[4];
    assign enables[5]    = memory_clock_enable_low_reg[5];
    assign enables[6]    = memory_clock_enable_low_reg[6];
    assign enables[7]    = memory_clock_enable_low_reg[7];
    // fourth byte: memory 11..8 and the free-running graphics clock
    assign enables[8]    = memory_graphics_clock_enable_high_reg[`POS_MEM_8];
    assign enables[9]    = memory_graphics_clock_enable_high_reg[`POS_MEM_9];
    assign enables[10]   = memory_graphics_clock_enable_high_reg[`POS_MEM_10] & desktop;
    assign enables[11]   = memory_graphics_clock_enable_high_reg[`POS_MEM_11] & desktop;
    assign enables[12]   = memory_graphics_clock_enable_high_reg[`POS_GFX_FREE];
    // fifth byte: graphics pair and reference; mode and reserved bits gate nothing
    // the sixth byte gates nothing at all
    assign enables[13]   = peripheral_clock_enable_reg[`POS_GFX_0];
    assign enables[14]   = peripheral_clock_enable_reg[`POS_GFX_1];
    assign enables[15]   = peripheral_clock_enable_reg[`POS_REF];

    // source selection per output
    // memory outputs share one source, so they stay in phase with each other
    assign sources[11:0]  = {12{mem_src_clk_in}};
    // the free-running and the two gated graphics outputs share a source
    assign sources[14:12] = {3{graphics_src_clk_in}};
    // the reference output runs from the crystal source
    assign sources[15]    = ref_src_clk_in;

    // one gate per output, each registered
    // registering costs a cycle of latency but keeps every output on a flop,
    // so no combinational glitch can reach a pin
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1)
        begin : gate_bank
            clock_gate_cell u_gate
            (
                .clock_in      (clock_in),
                .reset_n_in    (reset_n_in),
                .src_clk_in    (sources[gi]),
                .enable_in     (enables[gi]),
                .gated_clk_out (gated[gi])
            );
        end
    endgenerate

    // memory outputs 7..0, driven by the third byte
    assign mem_clk_out_0      = gated[0];
    assign mem_clk_out_1      = gated[1];
    assign mem_clk_out_2      = gated[2];
    assign mem_clk_out_3      = gated[3];
    assign mem_clk_out_4      = gated[4];
    assign mem_clk_out_5      = gated[5];
    assign mem_clk_out_6      = gated[6];
    assign mem_clk_out_7      = gated[7];

    // memory outputs 11..8; the upper pair runs in desktop mode only
    assign mem_clk_out_8      = gated[8];
    assign mem_clk_out_9      = gated[9];
    assign mem_clk_out_10     = gated[10];
    assign mem_clk_out_11     = gated[11];

    // graphics outputs
    assign graphics_clk_free  = gated[12];
    assign graphics_clk_out_0 = gated[13];
    assign graphics_clk_out_1 = gated[14];
    // reference output
    assign crystal_ref_out    = gated[15];

endmodule

`default_nettype wire

// [clock_enable_map.vh]
`ifndef CLOCK_ENABLE_MAP_VH
`define CLOCK_ENABLE_MAP_VH

// byte indices in the serial configuration sequence
`define IDX_MEM_LOW          3'h3
`define IDX_MEM_GFX_HIGH     3'h4
`define IDX_PERIPHERAL       3'h5
`define IDX_FUTURE_RSVD      3'h6
`define IDX_WIDTH            3

// power-up defaults of the enable bytes
`define RST_MEM_LOW          8'hff
`define RST_MEM_GFX_HIGH     8'hff
`define RST_PERIPHERAL       8'hff
`define RST_FUTURE_RSVD      8'hff

// field positions, high enable byte
`define POS_GFX_FREE         7
`define POS_MEM_11           3
`define POS_MEM_10           2
`define POS_MEM_9            1
`define POS_MEM_8            0

// field positions, peripheral byte
`define POS_GFX_0            4
`define POS_MODE             2
`define POS_GFX_1            1
`define POS_REF              0

// strap level that selects desktop mode
`define DESKTOP_STRAP        1'b1

`endif

// [clock_gate_cell.v]
`timescale 1ns/10ps
`default_nettype none

// one glitch-free output gate: the enable is only sampled while the source is low
module clock_gate_cell
(
    input  wire clock_in,
    input  wire reset_n_in,
    input  wire src_clk_in,
    input  wire enable_in,
    output reg  gated_clk_out
);

    reg  enable_live_reg;  // enable as currently applied to the output
    wire enable_eff;       // enable seen this cycle

    // a change arriving mid-high waits for the low phase, so no runt pulse
    assign enable_eff = src_clk_in ? enable_live_reg : enable_in;

    // output registered; held low when disabled
    always @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            enable_live_reg <= 1'b1;
            gated_clk_out   <= 1'b0;
        end
        else
        begin
            enable_live_reg <= enable_eff;
            gated_clk_out   <= src_clk_in & enable_eff;
        end
    end

endmodule

`default_nettype wire

// [cken_props.sv]
`timescale 1ns/10ps
`default_nettype none
// pin-level checker; enables are seen only through read-back and gated outputs
module cken_props
(
    input wire logic       clock_in,
    input wire logic       reset_n_in,
    input wire logic [2:0] read_index_in,
    input wire logic       mode_strap_in,
    input wire logic       mem_src_clk_in,
    input wire logic       ref_src_clk_in,
    input wire logic [7:0] read_data_out,
    input wire logic       mem_clk_out_0,
    input wire logic       mem_clk_out_11,
    input wire logic       crystal_ref_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    // strap is latched and registers settled a few edges after release
    sequence settled_s;
        $past(reset_n_in) && $past(reset_n_in, 3);
    endsequence
    // a stored zero in bit 0 seen while the source is low
    sequence mem0_off_s;
        $past(read_index_in) == 3'h3 && !read_data_out[0] && !mem_src_clk_in;
    endsequence
    mem_off_a: assert property (settled_s ##0 mem0_off_s |=> !mem_clk_out_0 [*2])
        else $error("memory output 0 not held low");
    mem_rise_a: assert property (mem_clk_out_0 |-> $past(mem_src_clk_in)) else $error("memory output 0 high without source");
    narrow_mode_a: assert property (settled_s ##0 !mode_strap_in |-> !mem_clk_out_11) else $error("output 11 runs outside desktop mode");
    mode_read_a: assert property (settled_s ##0 $past(read_index_in) == 3'h5 |-> read_data_out[2] == mode_strap_in)
        else $error("mode bit read back wrong");
    unmapped_read_a: assert property ($past(read_index_in) inside {3'h0, 3'h1, 3'h2, 3'h7} |-> read_data_out == 8'h00)
        else $error("unmapped index read not zero");
    mem_fall_a: assert property ($fell(mem_clk_out_0) |-> !$past(mem_src_clk_in)) else $error("memory pulse cut short");
    ref_fall_a: assert property ($fell(crystal_ref_out) |-> !$past(ref_src_clk_in)) else $error("reference pulse cut short");
endmodule
bind clock_output_enable_regs cken_props u_cken_props (.clock_in, .reset_n_in, .read_index_in, .mode_strap_in,
    .mem_src_clk_in, .ref_src_clk_in, .read_data_out, .mem_clk_out_0, .mem_clk_out_11, .crystal_ref_out);
`default_nettype wire

// [cfg_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
// configuration host: start pulse, then bytes 0..6 back to back
module cfg_host_model
(
    input  wire logic       clock_in,
    output var  logic       seq_start_out,
    output var  logic       seq_valid_out,
    output var  logic [7:0] seq_byte_out
);
    initial {seq_start_out, seq_valid_out, seq_byte_out} = 10'h000;
    // b holds bytes 6..3; bytes 0..2 belong to other blocks and go as zero
    task automatic send(input logic [31:0] b);
        @(negedge clock_in) seq_start_out = 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            @(negedge clock_in) seq_start_out = 1'b0;
            seq_valid_out = 1'b1;
            seq_byte_out = (i < 3) ? 8'h00 : b[8*(i-3) +: 8];
        end
        @(negedge clock_in) seq_valid_out = 1'b0;
        seq_byte_out = ~seq_byte_out; // released data is not left looking valid
    endtask
endmodule
`default_nettype wire

// [clock_output_enable_regs_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module clock_output_enable_regs_tb;
    logic clock_in = 1'b0, reset_n_in = 1'b0, mode_strap_in = 1'b1, clr = 1'b0, seq_start, seq_valid;
    logic [2:0] read_index_in = 3'h0, src = 3'h0;  // src: memory, graphics, reference sources
    logic [7:0] seq_byte, read_data_out, r;
    logic [15:0] seen = 16'h0000, exp, got;
    wire logic [15:0] mem;  // memory 11..0, graphics free, graphics 0, graphics 1, reference
    logic [1:0] look = 2'd0;  // 1 read-back due, 2 gate summary due
    logic [15:0] notes[$];
    int n_mismatch = 0, checked = 0;
    always #2.5 clock_in = ~clock_in;
    // memory toggles each cycle, graphics every 2, reference every 4
    always @(negedge clock_in) src <= src + 3'h1;
    // which gated outputs ever went high since the last clear
    always @(posedge clock_in) seen <= clr ? 16'h0000 : (seen | mem);
    cfg_host_model u_cfg_host_model (.clock_in(clock_in), .seq_start_out(seq_start), .seq_valid_out(seq_valid),
        .seq_byte_out(seq_byte));
    clock_output_enable_regs u_clock_output_enable_regs (.clock_in(clock_in), .reset_n_in(reset_n_in),
        .seq_start_in(seq_start), .seq_byte_valid_in(seq_valid), .seq_byte_in(seq_byte), .read_index_in(read_index_in),
        .mode_strap_in(mode_strap_in), .mem_src_clk_in(src[0]), .graphics_src_clk_in(src[1]), .ref_src_clk_in(src[2]),
        .read_data_out(read_data_out), .mem_clk_out_0(mem[0]), .mem_clk_out_1(mem[1]), .mem_clk_out_2(mem[2]),
        .mem_clk_out_3(mem[3]), .mem_clk_out_4(mem[4]), .mem_clk_out_5(mem[5]), .mem_clk_out_6(mem[6]),
        .mem_clk_out_7(mem[7]), .mem_clk_out_8(mem[8]), .mem_clk_out_9(mem[9]), .mem_clk_out_10(mem[10]),
        .mem_clk_out_11(mem[11]), .graphics_clk_free(mem[12]), .graphics_clk_out_0(mem[13]),
        .graphics_clk_out_1(mem[14]), .crystal_ref_out(mem[15]));
    // watcher: takes the oldest note once the result has landed
    always @(posedge clock_in) if (look != 2'd0)
    begin
        #1;
        exp = notes.pop_front();
        got = (look == 2'd1) ? read_data_out : seen;
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", (look == 2'd1) ? "read_data_out" : "gated outputs", exp, got);
        end
    end
    task automatic rd(input logic [2:0] idx, input logic [7:0] e);
        @(negedge clock_in) read_index_in = idx;
        notes.push_back({8'h00, e});
        look = 2'd1;
        @(negedge clock_in) look = 2'd0;
    endtask
    // ten cycles is plenty for a new enable to reach a low source
    task automatic gate(input logic [15:0] e);
        @(negedge clock_in) clr = 1'b1;
        repeat (10) @(negedge clock_in) clr = 1'b0;
        notes.push_back(e);
        look = 2'd2;
        @(negedge clock_in) look = 2'd0;
    endtask
    task automatic do_reset(input logic strap);
        reset_n_in = 1'b0;  // called at time zero or just after a falling edge
        mode_strap_in = strap;
        repeat (3) @(negedge clock_in);
        reset_n_in = 1'b1;
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        void'($urandom(32'h8161_7081));
        do_reset(1'b1);
        rd(3'h4, 8'hff);
        rd(3'h5, 8'hff);
        rd(3'h6, 8'hff);
        rd(3'h7, 8'h00);
        rd(3'h3, 8'hff);
        gate(16'hffff);
        $display("defaults test done");
        r = 8'($urandom) & 8'hfe;
        u_cfg_host_model.send({8'h00, 8'h00, 8'h70, r});
        rd(3'h4, 8'h70);
        rd(3'h5, 8'h04);
        rd(3'h6, 8'h00);
        rd(3'h3, r);
        gate({8'h00, r});
        $display("write test done");
        do_reset(1'b0);
        rd(3'h5, 8'hfb);
        rd(3'h0, 8'h00);
        gate(16'hf3ff);
        $display("narrow mode test done");
        tally_and_finish();
    end
    initial
    begin
        #20000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
